// ===== logic/spdtx_params.svh
// Constants shared by both ends of the serial audio input link.
// Assumes a 100 MHz core_clk on each end.
`ifndef SPDTX_PARAMS_SVH
`define SPDTX_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and pin timing
// ----------------------------------------------------------------
`define SPDTX_CORE_PERIOD_NS   10
`define SPDTX_SCLK_MIN_NS      80
`define SPDTX_SCLK_HALF_CYC    (((`SPDTX_SCLK_MIN_NS / 2) + `SPDTX_CORE_PERIOD_NS - 1) / `SPDTX_CORE_PERIOD_NS)
`define SPDTX_OVS_HALF_CYC     2

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define SPDTX_BITS_PER_HALF    32
`define SPDTX_BITS_PER_FRAME   64
`define SPDTX_CELLS_PER_SUB    64
`define SPDTX_SAMPLE_W         24
`define SPDTX_FIFO_DEPTH       8
`define SPDTX_I2S_DELAY        1
`define SPDTX_WIDTH_16         16
`define SPDTX_WIDTH_18         18
`define SPDTX_WIDTH_20         20
`define SPDTX_WIDTH_24         24

// ----------------------------------------------------------------
// Oversampling divisors: ratio / 128 biphase cells per frame
// ----------------------------------------------------------------
`define SPDTX_DIV_768          6
`define SPDTX_DIV_512          4
`define SPDTX_DIV_384          3
`define SPDTX_DIV_256          2

`endif

// ===== logic/spdtx_pkg.sv
// Types shared by both ends of the serial audio input link.
// Assumes nothing beyond the parameter header.
package spdtx_pkg;

  typedef enum logic [1:0]
  {
    SPDTX_FMT_I2S = 2'h0,
    SPDTX_FMT_LJ  = 2'h1,
    SPDTX_FMT_RJ  = 2'h2
  } spdtx_fmt_t;

  typedef enum logic [1:0]
  {
    SPDTX_WID_16 = 2'h0,
    SPDTX_WID_18 = 2'h1,
    SPDTX_WID_20 = 2'h2,
    SPDTX_WID_24 = 2'h3
  } spdtx_wid_t;

  typedef enum logic [1:0]
  {
    SPDTX_OVS_768 = 2'h0,
    SPDTX_OVS_512 = 2'h1,
    SPDTX_OVS_384 = 2'h2,
    SPDTX_OVS_256 = 2'h3
  } spdtx_ovs_t;

endpackage

// ===== logic/spdtx_if.sv
// Serial audio link between a sample source and the transmitter input.
// Assumes the testbench instantiates it and binds both modports.
`timescale 1ns/100ps

interface spdtx_if;
  logic bit_clk;
  logic chan_sel;
  logic serial_sample_data;
  logic oversampling_clock;

  modport src
  (
    output bit_clk,
    output chan_sel,
    output serial_sample_data,
    output oversampling_clock
  );

  modport port
  (
    input  bit_clk,
    input  chan_sel,
    input  serial_sample_data,
    input  oversampling_clock
  );
endinterface

// ===== logic/spdtx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps

module spdtx_fifo
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
)
(
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ===== logic/spdtx_port.sv
// Transmitter serial input port: deframes samples, buffers them and
// paces them out on the biphase cell rate.
// Assumes link pins are asynchronous to core_clk; one core clock only.
`timescale 1ns/100ps
`include "spdtx_params.svh"

// What this block does
// - Three framings, widths 16, 18, 20, 24
// - Sample data and select on bit-clock rise
// - Right-justified: select high means left
// - Right-justified MSB delayed by 32 minus width
// - I2S framing is the default
// - I2S: select low left, MSB one late
// - Left-justified: select high left, MSB immediate
// - Biphase clock divided from oversampling clock
// - Divider matches 768, 512, 384, 256 ratios
module spdtx_port
(
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  spdtx_if.port                         lnk,
  input  wire spdtx_pkg::spdtx_fmt_t    fmt,
  input  wire spdtx_pkg::spdtx_wid_t    wid,
  input  wire spdtx_pkg::spdtx_ovs_t    ovs_ratio,
  input  wire logic                     overflow_clr,
  output      logic                     biphase_tick,
  output      logic [`SPDTX_SAMPLE_W-1:0] tx_sample,
  output      logic                     tx_left,
  output      logic                     tx_valid,
  output      logic                     overflow
);
  import spdtx_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;

  // Pins are only ever read; nothing here drives them
  assign pin_raw = {lnk.oversampling_clock, lnk.serial_sample_data,
                    lnk.chan_sel, lnk.bit_clk};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic bclk_s;
  logic cs_s;
  logic sd_s;
  logic ovs_s;
  logic bclk_prev_q;
  logic ovs_prev_q;
  logic bclk_rise;
  logic ovs_rise;

  assign bclk_s    = sync_q[0];
  assign cs_s      = sync_q[1];
  assign sd_s      = sync_q[2];
  assign ovs_s     = sync_q[3];
  assign bclk_rise = bclk_s && !bclk_prev_q;
  assign ovs_rise  = ovs_s && !ovs_prev_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bclk_prev_q <= 1'b0;
      ovs_prev_q  <= 1'b0;
    end
    else
    begin
      bclk_prev_q <= bclk_s;
      ovs_prev_q  <= ovs_s;
    end
  end

  // ----------------------------------------------------------------
  // Word width and MSB position
  // ----------------------------------------------------------------
  logic [5:0] width;
  logic [5:0] start;
  logic [5:0] last;

  always_comb
  begin
    unique case (wid)
      SPDTX_WID_16: width = 6'(`SPDTX_WIDTH_16);
      SPDTX_WID_18: width = 6'(`SPDTX_WIDTH_18);
      SPDTX_WID_20: width = 6'(`SPDTX_WIDTH_20);
      SPDTX_WID_24: width = 6'(`SPDTX_WIDTH_24);
    endcase
  end

  always_comb
  begin
    // Unused encoding falls back to I2S
    case (fmt)
      SPDTX_FMT_LJ: start = 6'h00;
      SPDTX_FMT_RJ: start = 6'(`SPDTX_BITS_PER_HALF) - width;
      default:      start = 6'(`SPDTX_I2S_DELAY);
    endcase
  end

  assign last = start + width - 6'h01;

  // ----------------------------------------------------------------
  // Deframer
  // ----------------------------------------------------------------
  logic                       cs_prev_q;
  logic [5:0]                 idx_q;
  logic [5:0]                 bit_idx;
  logic                       cs_edge;
  logic [`SPDTX_SAMPLE_W-1:0] shift_q;
  logic                       push_q;
  logic                       push_left_q;
  logic                       left_now;

  assign cs_edge = (cs_s != cs_prev_q);
  // The bit taken on the edge that shows a new select level is bit 0
  assign bit_idx = cs_edge ? 6'h00 : idx_q;
  assign left_now = (fmt == SPDTX_FMT_LJ || fmt == SPDTX_FMT_RJ) ? cs_s : !cs_s;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_prev_q <= 1'b0;
      idx_q     <= 6'h3f;
    end
    else if (bclk_rise)
    begin
      cs_prev_q <= cs_s;
      // Saturate so an over-long half frame never re-enters the window
      idx_q     <= (bit_idx == 6'h3f) ? 6'h3f : bit_idx + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_q     <= '0;
      push_q      <= 1'b0;
      push_left_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      if (bclk_rise && bit_idx >= start && bit_idx <= last)
      begin
        if (bit_idx == start)
        begin
          shift_q <= {{(`SPDTX_SAMPLE_W-1){1'b0}}, sd_s};
        end
        else
        begin
          shift_q <= {shift_q[`SPDTX_SAMPLE_W-2:0], sd_s};
        end
        if (bit_idx == last)
        begin
          push_q      <= 1'b1;
          push_left_q <= left_now;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  localparam int FW = `SPDTX_SAMPLE_W + 1;

  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic          overflow_q;

  spdtx_fifo
  #(
    .WIDTH (FW),
    .DEPTH (`SPDTX_FIFO_DEPTH)
  )
  u_fifo
  (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_left_q, shift_q}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // The serial source cannot be stalled, so a full buffer loses the word
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overflow_q <= 1'b0;
    end
    else if (push_q && !fifo_in_ready)
    begin
      overflow_q <= 1'b1;
    end
    else if (overflow_clr)
    begin
      overflow_q <= 1'b0;
    end
  end

  assign overflow = overflow_q;

  // ----------------------------------------------------------------
  // Biphase clock divider and sample pacing
  // ----------------------------------------------------------------
  logic [2:0] div_max;
  logic [2:0] div_q;
  logic       tick_q;
  logic [5:0] cell_q;

  always_comb
  begin
    unique case (ovs_ratio)
      SPDTX_OVS_768: div_max = 3'(`SPDTX_DIV_768 - 1);
      SPDTX_OVS_512: div_max = 3'(`SPDTX_DIV_512 - 1);
      SPDTX_OVS_384: div_max = 3'(`SPDTX_DIV_384 - 1);
      SPDTX_OVS_256: div_max = 3'(`SPDTX_DIV_256 - 1);
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (ovs_rise)
      begin
        if (div_q >= div_max)
        begin
          div_q  <= '0;
          tick_q <= 1'b1;
        end
        else
        begin
          div_q <= div_q + 3'h1;
        end
      end
    end
  end

  assign biphase_tick   = tick_q;
  // One word leaves per subframe of 64 biphase cells
  assign fifo_out_ready = tick_q && (cell_q == 6'(`SPDTX_CELLS_PER_SUB - 1));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cell_q <= '0;
    end
    else if (tick_q)
    begin
      cell_q <= cell_q + 6'h01;
    end
  end

  logic [`SPDTX_SAMPLE_W-1:0] sample_q;
  logic                       left_q;
  logic                       valid_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sample_q <= '0;
      left_q   <= 1'b0;
      valid_q  <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      valid_q  <= fifo_out_valid;
      sample_q <= fifo_out_valid ? fifo_out_data[`SPDTX_SAMPLE_W-1:0] : '0;
      left_q   <= fifo_out_valid && fifo_out_data[FW-1];
    end
  end

  assign tx_sample = sample_q;
  assign tx_left   = left_q;
  assign tx_valid  = valid_q;
endmodule

// ===== logic/spdtx_src.sv
// Serial audio source: makes bit clock, channel select, data and the
// oversampling clock from core_clk by dividers.
// Assumes one core clock; user supplies one stereo pair per frame.
`timescale 1ns/100ps
`include "spdtx_params.svh"

module spdtx_src
(
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  spdtx_if.src                            lnk,
  input  wire spdtx_pkg::spdtx_fmt_t      fmt,
  input  wire spdtx_pkg::spdtx_wid_t      wid,
  input  wire logic [`SPDTX_SAMPLE_W-1:0] snd_left,
  input  wire logic [`SPDTX_SAMPLE_W-1:0] snd_right,
  input  wire logic                       snd_valid,
  output      logic                       snd_ready
);
  import spdtx_pkg::*;

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [3:0] sdiv_q;
  logic       sclk_q;
  logic       fall;
  logic [3:0] odiv_q;
  logic       ovs_q;

  assign fall = (sdiv_q == 4'(`SPDTX_SCLK_HALF_CYC - 1)) && sclk_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdiv_q <= '0;
      sclk_q <= 1'b0;
    end
    else if (sdiv_q == 4'(`SPDTX_SCLK_HALF_CYC - 1))
    begin
      sdiv_q <= '0;
      sclk_q <= !sclk_q;
    end
    else
    begin
      sdiv_q <= sdiv_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      odiv_q <= '0;
      ovs_q  <= 1'b0;
    end
    else if (odiv_q == 4'(`SPDTX_OVS_HALF_CYC - 1))
    begin
      odiv_q <= '0;
      ovs_q  <= !ovs_q;
    end
    else
    begin
      odiv_q <= odiv_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Framer: data changes on the falling edge, stable at the rise
  // ----------------------------------------------------------------
  logic [5:0] width;
  logic [5:0] start;
  logic [5:0] pos_q;
  logic [5:0] pos_n;
  logic [4:0] idx;
  logic       second;
  logic       lr_bit;
  logic       dat_bit;
  logic [5:0] off;
  logic [`SPDTX_SAMPLE_W-1:0] word;
  logic [`SPDTX_SAMPLE_W-1:0] left_q;
  logic [`SPDTX_SAMPLE_W-1:0] right_q;
  logic       cs_q;
  logic       sd_q;
  logic       ready_q;

  always_comb
  begin
    unique case (wid)
      SPDTX_WID_16: width = 6'(`SPDTX_WIDTH_16);
      SPDTX_WID_18: width = 6'(`SPDTX_WIDTH_18);
      SPDTX_WID_20: width = 6'(`SPDTX_WIDTH_20);
      SPDTX_WID_24: width = 6'(`SPDTX_WIDTH_24);
    endcase
  end

  always_comb
  begin
    case (fmt)
      SPDTX_FMT_LJ: start = 6'h00;
      SPDTX_FMT_RJ: start = 6'(`SPDTX_BITS_PER_HALF) - width;
      default:      start = 6'(`SPDTX_I2S_DELAY);
    endcase
  end

  assign pos_n  = pos_q + 6'h01;
  assign second = pos_n[5];
  assign idx    = pos_n[4:0];
  // First half carries the left word
  assign lr_bit = (fmt == SPDTX_FMT_LJ || fmt == SPDTX_FMT_RJ) ? !second : second;
  assign word   = second ? right_q : left_q;
  assign off    = {1'b0, idx} - start;

  always_comb
  begin
    dat_bit = 1'b0;
    if ({1'b0, idx} >= start && off < width)
    begin
      dat_bit = word[5'(width - 6'h01 - off)];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pos_q   <= 6'h3f;
      cs_q    <= 1'b0;
      sd_q    <= 1'b0;
      left_q  <= '0;
      right_q <= '0;
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= 1'b0;
      if (fall)
      begin
        pos_q <= pos_n;
        cs_q  <= lr_bit;
        sd_q  <= dat_bit;
      end
      // Load the next pair one edge before it is needed
      if (fall && pos_n == 6'(`SPDTX_BITS_PER_FRAME - 1))
      begin
        left_q  <= snd_valid ? snd_left : '0;
        right_q <= snd_valid ? snd_right : '0;
        ready_q <= 1'b1;
      end
    end
  end

  assign snd_ready              = ready_q;
  assign lnk.bit_clk            = sclk_q;
  assign lnk.chan_sel           = cs_q;
  assign lnk.serial_sample_data = sd_q;
  assign lnk.oversampling_clock = ovs_q;
endmodule

// ===== tb/spdtx_sva.sv
// Checker for the serial audio link between the source and the port.
// Assumes the link pins are launched from core_clk by the source end.
`timescale 1ns/100ps

module spdtx_sva
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic bit_clk,
  input wire logic chan_sel,
  input wire logic serial_sample_data,
  input wire logic oversampling_clock
);
  logic       sel_q;
  logic       clk_q;
  logic       arm_q;
  logic [6:0] rise_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // Bit clock rises per half frame
  // ------------------------------------------------------------
  // Armed only after the first select edge: the half after reset may be partial
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_q  <= 1'b0;
      clk_q  <= 1'b0;
      arm_q  <= 1'b0;
      rise_q <= 7'h00;
    end
    else
    begin
      sel_q <= chan_sel;
      clk_q <= bit_clk;
      if (chan_sel != sel_q)
      begin
        arm_q  <= 1'b1;
        rise_q <= 7'h00;
      end
      else if (bit_clk && !clk_q)
        rise_q <= rise_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------
  chk_sclk_high:
  assert property ($rose(bit_clk) |-> bit_clk[*4] ##1 !bit_clk)
    else $error("bit clock high phase has the wrong length");
  chk_sclk_low:
  assert property ($fell(bit_clk) |-> !bit_clk[*4] ##1 bit_clk)
    else $error("bit clock low phase has the wrong length");
  chk_sel_hold:
  assert property (bit_clk |-> $stable(chan_sel))
    else $error("channel select moved while bit clock high");
  chk_data_hold:
  assert property (bit_clk |-> $stable(serial_sample_data))
    else $error("serial data moved while bit clock high");
  chk_sel_setup:
  assert property ($changed(chan_sel) |-> !bit_clk[*3])
    else $error("channel select changed too close to a rise");
  chk_half_len:
  assert property ((chan_sel != sel_q) && arm_q |-> rise_q == 7'h20)
    else $error("half frame does not hold 32 bit clocks");
  chk_ovs_high:
  assert property ($rose(oversampling_clock) |=> oversampling_clock ##1 !oversampling_clock)
    else $error("oversampling clock high phase wrong");
  chk_ovs_low:
  assert property ($fell(oversampling_clock) |=> !oversampling_clock ##1 oversampling_clock)
    else $error("oversampling clock low phase wrong");
endmodule

// ===== tb/tb_spdtx.sv
// Testbench joining the sample source and the transmitter input port.
// Assumes both ends share core_clk and nrst; FIFO is reached through the port.
`timescale 1ns/100ps
`include "spdtx_params.svh"

module tb_spdtx;
  import spdtx_pkg::*;
  logic        core_clk;
  logic        nrst;
  spdtx_fmt_t  fmt;
  spdtx_wid_t  wid;
  spdtx_ovs_t  ovs_ratio;
  logic [23:0] snd_left;
  logic [23:0] snd_right;
  logic [23:0] tx_sample;
  logic [23:0] mask;
  logic [31:0] hb;
  logic        snd_valid;
  logic        snd_ready;
  logic        overflow_clr;
  logic        biphase_tick;
  logic        tx_left;
  logic        tx_valid;
  logic        overflow;
  logic        left_lvl;
  logic        sel_p;
  logic        clk_p;
  logic [24:0] wq[$];
  logic [24:0] pq[$];
  bit          wlock;
  bit          plock;
  bit          pchk;
  bit          ovf_run;
  int          mismatches;
  int          n_tests;
  int          seed;
  int          wd_n;
  int          start_n;
  int          hidx;
  int          tcnt;

  spdtx_if lnk();

  spdtx_src u_spdtx_src (.core_clk(core_clk), .nrst(nrst), .lnk(lnk), .fmt(fmt), .wid(wid),
    .snd_left(snd_left), .snd_right(snd_right), .snd_valid(snd_valid), .snd_ready(snd_ready));
  spdtx_port u_spdtx_port (.core_clk(core_clk), .nrst(nrst), .lnk(lnk), .fmt(fmt), .wid(wid),
    .ovs_ratio(ovs_ratio), .overflow_clr(overflow_clr), .biphase_tick(biphase_tick),
    .tx_sample(tx_sample), .tx_left(tx_left), .tx_valid(tx_valid), .overflow(overflow));
  spdtx_sva u_spdtx_sva (.core_clk(core_clk), .nrst(nrst), .bit_clk(lnk.bit_clk),
    .chan_sel(lnk.chan_sel), .serial_sample_data(lnk.serial_sample_data),
    .oversampling_clock(lnk.oversampling_clock));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Leading zero words are the idle frame sent before the first pair
  task automatic take(input logic [24:0] obs, ref logic [24:0] q[$], ref bit lk);
    if (lk || obs[23:0] != 24'h00_0000)
    begin
      lk = 1'b1;
      check(obs, q.size() ? q.pop_front() : 'x);
    end
  endtask

  function automatic int width_of(input spdtx_wid_t w);
    int t[4] = '{16, 18, 20, 24};
    return t[w];
  endfunction

  function automatic int start_of(input spdtx_fmt_t f, input int n);
    return (f == SPDTX_FMT_RJ) ? 32 - n : (f == SPDTX_FMT_LJ) ? 0 : 1;
  endfunction

  function automatic logic [23:0] field(input logic [31:0] b, input int st, input int n);
    logic [23:0] r;
    r = 24'h00_0000;
    for (int i = 0; i < n; i++)
      r = {r[22:0], b[st + i]};
    return r;
  endfunction

  task run(input spdtx_fmt_t f, input spdtx_wid_t w, input int frames);
    nrst <= 1'b0;
    fmt <= f;
    wid <= w;
    repeat (5) @(posedge core_clk);
    wd_n = width_of(w);
    start_n = start_of(f, wd_n);
    left_lvl = (f == SPDTX_FMT_LJ || f == SPDTX_FMT_RJ);
    mask = 24'((32'h1 << wd_n) - 1);
    wq.delete();
    pq.delete();
    wlock = 1'b0;
    plock = 1'b0;
    nrst <= 1'b1;
    repeat (frames * 512) @(posedge core_clk);
  endtask

  task wait_tick(output int g);
    g = 0;
    do
    begin
      @(posedge core_clk);
      g++;
    end
    while (biphase_tick !== 1'b1 && g < 100);
  endtask

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (nrst && snd_ready === 1'b1)
    begin
      wq.push_back({1'b1, snd_left & mask});
      wq.push_back({1'b0, snd_right & mask});
      pq.push_back({1'b1, snd_left & mask});
      pq.push_back({1'b0, snd_right & mask});
      snd_left <= 24'($random(seed));
      snd_right <= 24'($random(seed));
    end
  end

  // Rebuilds each half frame from the wire, indexed from the select edge
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      hidx = 0;
      sel_p = 1'b0;
      clk_p = 1'b0;
    end
    else
    begin
      if (lnk.bit_clk === 1'b1 && clk_p === 1'b0)
      begin
        if (lnk.chan_sel !== sel_p)
        begin
          if (hidx == 32)
            take({sel_p == left_lvl, field(hb, start_n, wd_n)}, wq, wlock);
          sel_p = lnk.chan_sel;
          hidx = 0;
        end
        if (hidx < 32)
          hb[hidx] = lnk.serial_sample_data;
        hidx++;
      end
      clk_p = lnk.bit_clk;
    end
  end

  // A pop follows every 64th cell tick
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tcnt = 0;
      pchk = 1'b0;
    end
    else
    begin
      // Words are knowingly lost in the overflow scenario, so order is not tracked there
      if (pchk && tx_valid === 1'b1 && !ovf_run)
        take({tx_left, tx_sample}, pq, plock);
      pchk = biphase_tick === 1'b1 && tcnt == 63;
      if (biphase_tick === 1'b1)
        tcnt = (tcnt + 1) % 64;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    #600_000;
    mismatches++;
    tally_and_finish;
  end

  initial
  begin
    int g;
    int rat[4];
    seed = 32'h2c92_2f04;
    rat = '{768, 512, 384, 256};
    ovf_run = 1'b0;
    nrst = 1'b0;
    fmt = SPDTX_FMT_I2S;
    wid = SPDTX_WID_16;
    ovs_ratio = SPDTX_OVS_256;
    overflow_clr = 1'b0;
    snd_valid = 1'b1;
    snd_left = 24'($random(seed));
    snd_right = 24'($random(seed));
    run(SPDTX_FMT_I2S, SPDTX_WID_24, 0);
    for (int r = 0; r < 4; r++)
    begin
      ovs_ratio <= spdtx_ovs_t'(r[1:0]);
      repeat (3) wait_tick(g);
      wait_tick(g);
      check(g, 4 * rat[r] / 128);
    end
    ovs_ratio <= SPDTX_OVS_256;
    // Code 3 is undefined and must deframe as the default framing
    for (int f = 0; f < 4; f++)
      for (int w = 0; w < 4; w++)
        run(spdtx_fmt_t'(f[1:0]), spdtx_wid_t'(w[1:0]), 5);
    // Slowest pacing drains one word per three frames, so the buffer fills and drops
    ovf_run = 1'b1;
    ovs_ratio <= SPDTX_OVS_768;
    run(SPDTX_FMT_LJ, SPDTX_WID_16, 1);
    check(overflow, 1'b0);
    repeat (7 * 512) @(posedge core_clk);
    check(overflow, 1'b1);
    // Clear just after a select edge, far from the next push, so the set cannot win
    @(lnk.chan_sel);
    @(posedge core_clk);
    overflow_clr <= 1'b1;
    @(posedge core_clk);
    overflow_clr <= 1'b0;
    @(posedge core_clk);
    check(overflow, 1'b0);
    tally_and_finish;
  end
endmodule
